//--- bench/fma_issue_model.sv
// issue-side model: presents requests and flag clears to the datapath
`timescale 1ns/1ps
module fma_issue_model
  import fma_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic clr_i,
  input wire fma_req_type cmd_i,
  output logic valid_o,
  output logic flag_clear_o,
  output fma_req_type req_o
);
  // ======================================================
  // dispatch at the falling edge
  initial begin
    valid_o = 1'b0;
    flag_clear_o = 1'b0;
    req_o = '0;
  end
  always @(negedge clk_sys_i) begin
    valid_o <= go_i;
    flag_clear_o <= clr_i;
    // idle bus shows the inverse, so stale operands never pass for fresh
    req_o <= go_i ? cmd_i : fma_req_type'(~cmd_i);
  end
endmodule

//--- bench/fma_numerics_unit_asserts.sv
// port assertions for the fused multiply-add datapath
`timescale 1ns/1ps
module fma_numerics_unit_asserts
  import fma_pkg::*;
#(
  parameter int VEC_W = 256
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic valid_i,
  input wire fma_req_type req_i,
  input wire logic flag_clear_i,
  input wire logic valid_o,
  input wire logic [VEC_W-1:0] result_o,
  input wire logic invalid_o,
  input wire logic invalid_op_sticky_flag_o
);
  // ======================================================
  // timing, flag and lane placement
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_latency; valid_i |=> valid_o; endproperty
  a_latency: assert property (p_latency)
    else $error("result missing after request");
  property p_idle;
    !valid_i |=> !valid_o && !invalid_o && $stable(result_o);
  endproperty
  a_idle: assert property (p_idle)
    else $error("output moved without request");
  property p_set; invalid_o |-> valid_o && invalid_op_sticky_flag_o;
  endproperty
  a_set: assert property (p_set)
    else $error("invalid without sticky flag");
  property p_hold;
    invalid_op_sticky_flag_o && !flag_clear_i |=> invalid_op_sticky_flag_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("sticky flag lost");
  property p_clear;
    flag_clear_i && !valid_i |=> !invalid_op_sticky_flag_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("sticky flag not cleared");
  property p_rise; $rose(invalid_op_sticky_flag_o) |-> invalid_o;
  endproperty
  a_rise: assert property (p_rise)
    else $error("sticky flag set without event");
  property p_upper;
    valid_i && (req_i.op.scalar || !req_i.op.wide)
      |=> result_o[VEC_W-1:128] == '0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper half not zero");
  property p_keep;
    valid_i && req_i.op.scalar && req_i.op.dbl
      |=> result_o[127:64] == $past(req_i.src1[127:64]);
  endproperty
  a_keep: assert property (p_keep)
    else $error("scalar upper element changed");
  // only the multiplicand slot of the 132 order is watched here
  property p_signaling_nan_x;
    valid_i && req_i.op.dbl && req_i.op.order == ORD_132 &&
      req_i.src1[62:51] == 12'hFFE && req_i.src1[50:0] != '0
      |=> invalid_o &&
        result_o[63:0] == ($past(req_i.src1[63:0]) | 64'h0008000000000000);
  endproperty
  a_signaling_nan_x: assert property (p_signaling_nan_x)
    else $error("signaling multiplicand not quieted");
endmodule

bind fma_numerics_unit fma_numerics_unit_asserts #(.VEC_W(VEC_W)) chk (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .valid_i(valid_i),
  .req_i(req_i),
  .flag_clear_i(flag_clear_i),
  .valid_o(valid_o),
  .result_o(result_o),
  .invalid_o(invalid_o),
  .invalid_op_sticky_flag_o(invalid_op_sticky_flag_o)
);

//--- bench/fused_multiply_add_numerics_test.sv
// self-checking bench for the fused multiply-add datapath
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((e) !== (g)) begin \
    errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); \
  end \
end

module fused_multiply_add_numerics_test
  import fma_pkg::*;
();
  localparam logic [63:0] one_d = 64'h3FF0000000000000;
  localparam logic [63:0] two_d = 64'h4000000000000000;
  localparam logic [63:0] inf_d = 64'h7FF0000000000000;
  localparam logic [63:0] nz_d = 64'h8000000000000000;
  localparam logic [63:0] dnan = 64'hFFF8000000000000;
  localparam logic [63:0] qbit = 64'h0008000000000000;
  localparam logic [63:0] sn_a = 64'h7FF0000000000001;
  localparam logic [63:0] sn_b = 64'hFFF0000000000002;
  localparam logic [63:0] qn_c = 64'h7FF8000000000009;
  localparam logic [63:0] fx = 64'h3FF0000002000000;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic go = 1'b0;
  logic clr = 1'b0;
  fma_req_type cmd = '0;
  fma_req_type req_i;
  logic valid_i, flag_clear_i, valid_o, invalid_o, sticky;
  logic [255:0] result_o;
  logic [31:0] lf = 32'hCD41;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  fma_issue_model issuer (
    .clk_sys_i(clk_sys_i),
    .go_i(go),
    .clr_i(clr),
    .cmd_i(cmd),
    .valid_o(valid_i),
    .flag_clear_o(flag_clear_i),
    .req_o(req_i)
  );
  fma_numerics_unit dut (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .valid_i(valid_i),
    .req_i(req_i),
    .flag_clear_i(flag_clear_i),
    .valid_o(valid_o),
    .result_o(result_o),
    .invalid_o(invalid_o),
    .invalid_op_sticky_flag_o(sticky)
  );

  // ======================================================
  // helpers
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic int sv();
    logic [31:0] t;
    t = rnd();
    return int'(t[3:0]) - 8;
  endfunction
  // exact only for small integers, which is all the bench feeds it
  // zn gives the sign that an exact zero result must carry
  function automatic logic [63:0] fl(logic d, real r, logic zn);
    logic [63:0] b;
    logic [10:0] e;
    b = $realtobits(r);
    e = b[62:52] - 11'h380;
    if (!d) b = {32'h0, b[63], e[7:0], b[51:29]};
    if (r == 0.0 && d) b = {zn, 63'h0};
    if (r == 0.0 && !d) b = {32'h0, zn, 31'h0};
    return b;
  endfunction
  task automatic put(inout logic [255:0] v, input logic d, input int i,
                     input logic [63:0] e);
    if (d) v[64*i +: 64] = e;
    else v[32*i +: 32] = e[31:0];
  endtask
  // go stays high across calls, so calls in a row go back to back
  task automatic run(fma_req_type c);
    go = 1'b1;
    cmd = c;
    @(posedge clk_sys_i);
    #1;
    `CHK("valid", 1'b1, valid_o)
  endtask
  task automatic dc(logic [63:0] x, y, z, logic [1:0] v, rm_type m,
                    logic [63:0] e, logic inv);
    fma_req_type c;
    c = '0;
    c.op.dbl = 1'b1;
    c.op.scalar = 1'b1;
    c.op.variant = v;
    c.op.rm = m;
    c.src1[63:0] = x;
    c.src3[63:0] = y;
    c.src2[63:0] = z;
    run(c);
    `CHK("lane0", e, result_o[63:0])
    `CHK("invalid", inv, invalid_o)
  endtask

  // ======================================================
  // main sequence
  initial begin
    fma_req_type c;
    logic [255:0] ex;
    logic [31:0] t;
    logic zn;
    int x, y, z, nl;
    int s [3];
    real r;
    repeat (8) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    for (int k = 0; k < 48; k++) begin
      t = rnd();
      c = '0;
      c.op = fma_op_type'({t[2:0], t[4:3], 2'(k % 3), t[6:5]});
      nl = c.op.dbl ? 4 : 8;
      ex = '0;
      for (int i = 0; i < nl; i++) begin
        x = sv();
        y = sv();
        z = sv();
        case (k % 3)
          0: s = '{x, z, y};
          1: s = '{y, x, z};
          default: s = '{z, x, y};
        endcase
        put(c.src1, c.op.dbl, i, fl(c.op.dbl, s[0], 1'b0));
        put(c.src2, c.op.dbl, i, fl(c.op.dbl, s[1], 1'b0));
        put(c.src3, c.op.dbl, i, fl(c.op.dbl, s[2], 1'b0));
        r = (c.op.variant.neg_prod ? -1.0 : 1.0) * x * y;
        r = r + (c.op.variant.neg_addend ? -1.0 : 1.0) * z;
        // cancellation follows the mode; two like-signed zeros keep sign
        zn = (c.op.rm == RM_DOWN);
        if ((x == 0 || y == 0) && z == 0
            && (((x < 0) ^ (y < 0) ^ c.op.variant.neg_prod)
                == c.op.variant.neg_addend))
          zn = c.op.variant.neg_addend;
        if (i >= nl / 2 && (c.op.scalar || !c.op.wide)) r = r;
        else if (c.op.scalar && i > 0)
          put(ex, c.op.dbl, i, fl(c.op.dbl, s[0], 1'b0));
        else put(ex, c.op.dbl, i, fl(c.op.dbl, r, zn));
      end
      run(c);
      `CHK("vector", ex, result_o)
      `CHK("invalid", 1'b0, invalid_o)
    end
    dc(sn_a, one_d, qn_c, 2'd0, RM_NEAREST, sn_a | qbit, 1'b1);
    dc(qn_c, one_d, sn_b, 2'd1, RM_UP, qn_c, 1'b1);
    dc(two_d, sn_b, qn_c, 2'd1, RM_ZERO, sn_b | qbit, 1'b1);
    dc(one_d, two_d, qn_c, 2'd2, RM_DOWN, qn_c, 1'b0);
    dc(one_d, two_d, sn_b, 2'd3, RM_NEAREST, sn_b | qbit, 1'b1);
    dc(inf_d, two_d, inf_d, 2'd0, RM_NEAREST, inf_d, 1'b0);
    dc(inf_d, two_d, inf_d, 2'd3, RM_DOWN, inf_d | nz_d, 1'b0);
    dc(inf_d, two_d, inf_d, 2'd1, RM_NEAREST, dnan, 1'b1);
    dc(inf_d, two_d, inf_d, 2'd2, RM_UP, dnan, 1'b1);
    // product rounded on its own would lose the low term
    dc(fx, fx, 64'hBFF0000000000000, 2'd0, RM_NEAREST,
       64'h3E50000001000000, 1'b0);
    for (int m = 0; m < 4; m++) begin
      dc(nz_d, one_d, nz_d, 2'd0, rm_type'(m), nz_d, 1'b0);
      dc('0, one_d, nz_d, 2'd0, rm_type'(m), {m == 1, 63'h0}, 1'b0);
    end
    `CHK("sticky", 1'b1, sticky)
    // clear in the same cycle as a new invalid event loses
    clr = 1'b1;
    dc(inf_d, two_d, inf_d, 2'd1, RM_NEAREST, dnan, 1'b1);
    `CHK("sticky", 1'b1, sticky)
    go = 1'b0;
    @(posedge clk_sys_i);
    #1;
    `CHK("valid", 1'b0, valid_o)
    `CHK("sticky", 1'b0, sticky)
    clr = 1'b0;
    results();
  end
endmodule

//--- hw/fma_defs.svh
// numeric constants for the fused multiply-add datapath
`ifndef FMA_DEFS_SVH
`define FMA_DEFS_SVH

// ==========================================================
// vector and lane geometry
`define VEC_BITS 256
`define HALF_BITS 128
`define DP_BITS 64
`define SP_BITS 32
`define DP_LANES 4
`define SP_LANES 8

// ==========================================================
// internal datapath widths
`define EXP_W 15
`define SIG_W 53
`define PROD_W 106
`define ACC_W 110
`define PROD_PAD 4'h0
`define ADD_PAD 57'h0
`define SP_FRAC_PAD 29'h0

// ==========================================================
// format encodings
`define DP_BIAS 15'sh03FF
`define SP_BIAS 15'sh007F
`define EXP_ONE 15'sh0001
`define EXP_FLOOR 15'sh7000
`define DP_EXP_ONES 11'h7FF
`define SP_EXP_ONES 11'h0FF
`define DP_EXP_MAX 11'h7FE
`define SP_EXP_MAX 11'h0FE
`define FRAC_ONES 52'hFFFFFFFFFFFFF
`define DP_QUIET_NAN 64'hFFF8000000000000
`define SP_QUIET_NAN 64'h00000000FFC00000
`define DP_QUIET 64'h0008000000000000
`define SP_QUIET 64'h0000000000400000

`endif

//--- hw/fma_numerics_unit.sv
// fused multiply-add datapath, packed and scalar, one cycle
`timescale 1ns/1ps
`include "fma_defs.svh"

module fma_numerics_unit
  import fma_pkg::*;
#(
  parameter int VEC_W = `VEC_BITS
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic valid_i,
  input wire fma_req_type req_i,
  input wire logic flag_clear_i,
  output logic valid_o,
  output logic [VEC_W-1:0] result_o,
  output logic invalid_o,
  output logic invalid_op_sticky_flag_o
);

  // ========================================================
  // elaboration check
  if (VEC_W != `VEC_BITS) begin : g_bad_width
    $error("vector width must match the request carrier");
  end

  // ========================================================
  // helpers
  function automatic logic [6:0] lead_zeros(
    input logic [`ACC_W-1:0] v
  );
    logic found;
    lead_zeros = 7'h00;
    found = 1'b0;
    for (int i = `ACC_W - 1; i >= 0; i--) begin
      if (!found) begin
        if (v[i]) begin
          found = 1'b1;
        end else begin
          lead_zeros = lead_zeros + 7'h01;
        end
      end
    end
  endfunction

  // right shift that folds lost bits into bit 0
  function automatic logic [`ACC_W-1:0] shr_sticky(
    input logic [`ACC_W-1:0] v,
    input logic [`EXP_W-1:0] amt
  );
    logic [7:0] s;
    logic lost;
    s = (amt > `EXP_W'(`ACC_W)) ? 8'(`ACC_W) : amt[7:0];
    lost = (v << (8'(`ACC_W) - s)) != '0;
    shr_sticky = (v >> s) | {{(`ACC_W - 1){1'b0}}, lost};
  endfunction

  function automatic operand_type unpack(
    input logic [`DP_BITS-1:0] w,
    input logic dbl
  );
    logic [10:0] ef;
    logic [51:0] fr;
    logic ones;
    logic signed [`EXP_W-1:0] bias;
    if (dbl) begin
      ef = w[62:52];
      fr = w[51:0];
      unpack.sgn = w[63];
      ones = &w[62:52];
      bias = `DP_BIAS;
    end else begin
      ef = {3'h0, w[30:23]};
      fr = {w[22:0], `SP_FRAC_PAD};
      unpack.sgn = w[31];
      ones = &w[30:23];
      bias = `SP_BIAS;
    end
    unpack.zero = (ef == 11'h000) && (fr == '0);
    unpack.inf = ones && (fr == '0);
    unpack.nan = ones && (fr != '0);
    unpack.signaling_nan = unpack.nan && !fr[51];
    unpack.sig = {ef != 11'h000, fr};
    // subnormals share the smallest normal exponent
    unpack.expo = $signed({4'h0, (ef == 11'h000) ? 11'h001 : ef})
                  - bias;
  endfunction

  function automatic logic [`DP_BITS-1:0] pack(
    input logic s,
    input logic [10:0] e,
    input logic [51:0] m,
    input logic dbl
  );
    pack = dbl ? {s, e, m} : {32'h0, s, e[7:0], m[22:0]};
  endfunction

  // ========================================================
  // one element: special cases, then exact sum, one rounding
  function automatic logic [`DP_BITS:0] fma_elem(
    input logic [`DP_BITS-1:0] a,
    input logic [`DP_BITS-1:0] b,
    input logic [`DP_BITS-1:0] c,
    input logic dbl,
    input variant_type vr,
    input rm_type rm
  );
    operand_type ux;
    operand_type uy;
    operand_type uz;
    logic ps;
    logic zs;
    logic sb;
    logic eff_sub;
    logic pbig;
    logic g;
    logic st;
    logic inc;
    logic inv;
    logic ovf_inf;
    logic [`DP_BITS-1:0] res;
    logic [`DP_BITS-1:0] qbit;
    logic [`DP_BITS-1:0] quiet_nan;
    logic [10:0] e_ones;
    logic [10:0] e_max;
    logic [`PROD_W-1:0] prod;
    logic [`ACC_W-1:0] pw;
    logic [`ACC_W-1:0] zw;
    logic [`ACC_W-1:0] bg;
    logic [`ACC_W-1:0] sm;
    logic [`ACC_W-1:0] sum;
    logic [`ACC_W-1:0] n;
    logic [6:0] lp;
    logic [6:0] lz;
    logic [6:0] l2;
    logic signed [`EXP_W-1:0] ep;
    logic signed [`EXP_W-1:0] ez;
    logic signed [`EXP_W-1:0] eb;
    logic signed [`EXP_W-1:0] er;
    logic signed [`EXP_W-1:0] bias;
    logic signed [`EXP_W-1:0] emin;
    logic [`SIG_W:0] mt;
    logic [10:0] ef;
    ux = unpack(a, dbl);
    uy = unpack(b, dbl);
    uz = unpack(c, dbl);
    bias = dbl ? `DP_BIAS : `SP_BIAS;
    emin = `EXP_ONE - bias;
    qbit = dbl ? `DP_QUIET : `SP_QUIET;
    quiet_nan = dbl ? `DP_QUIET_NAN : `SP_QUIET_NAN;
    e_ones = dbl ? `DP_EXP_ONES : `SP_EXP_ONES;
    e_max = dbl ? `DP_EXP_MAX : `SP_EXP_MAX;
    ps = ux.sgn ^ uy.sgn ^ vr.neg_prod;
    zs = uz.sgn ^ vr.neg_addend;
    eff_sub = ps ^ zs;
    // any signaling input makes the nan cases invalid
    inv = ux.signaling_nan | uy.signaling_nan | uz.signaling_nan;
    // full 106-bit product, nothing dropped
    prod = ux.sig * uy.sig;
    pw = {prod, `PROD_PAD};
    lp = lead_zeros(pw);
    pw = (pw << lp) >> 1;
    ep = ux.expo + uy.expo + `EXP_ONE - $signed({8'h00, lp});
    zw = {uz.sig, `ADD_PAD};
    lz = lead_zeros(zw);
    zw = (zw << lz) >> 1;
    ez = uz.expo - $signed({8'h00, lz});
    // a zero term must never be chosen over a nonzero one; when both are zero the product side is taken
    if (ux.zero | uy.zero) begin
      ep = `EXP_FLOOR;
    end
    if (uz.zero) begin
      ez = `EXP_FLOOR;
    end
    pbig = (ep > ez) || ((ep == ez) && (pw >= zw));
    bg = pbig ? pw : zw;
    sm = pbig ? zw : pw;
    eb = pbig ? ep : ez;
    sb = pbig ? ps : zs;
    sm = shr_sticky(sm, pbig ? ep - ez : ez - ep);
    // larger magnitude first, so the difference is never negative
    sum = eff_sub ? bg - sm : bg + sm;
    l2 = lead_zeros(sum);
    n = sum << l2;
    er = eb + `EXP_ONE - $signed({8'h00, l2});
    if (er < emin) begin
      n = shr_sticky(n, emin - er);
      er = emin;
    end
    if (dbl) begin
      mt = {1'b0, n[109:57]};
      g = n[56];
      st = |n[55:0];
    end else begin
      mt = {30'h0, n[109:86]};
      g = n[85];
      st = |n[84:0];
    end
    case (rm)
      RM_NEAREST: begin
        inc = g & (st | mt[0]);
      end
      RM_DOWN: begin
        inc = sb & (g | st);
      end
      RM_UP: begin
        inc = !sb & (g | st);
      end
      default: begin
        inc = 1'b0;
      end
    endcase
    mt = mt + {{`SIG_W{1'b0}}, inc};
    if (dbl ? mt[53] : mt[24]) begin
      mt = mt >> 1;
      er = er + `EXP_ONE;
    end
    // a rounded subnormal may carry into the smallest normal
    ef = (dbl ? mt[52] : mt[23]) ? 11'(er + bias) : 11'h000;
    ovf_inf = (rm == RM_NEAREST) || ((rm == RM_DOWN) && sb)
              || ((rm == RM_UP) && !sb);
    if (ux.nan) begin
      res = a | qbit;
    end else if (uy.nan) begin
      res = b | qbit;
    end else if (uz.nan) begin
      res = c | qbit;
    end else if ((ux.inf & uy.zero) | (ux.zero & uy.inf)) begin
      res = quiet_nan;
      inv = 1'b1;
    end else if ((ux.inf | uy.inf) & uz.inf & eff_sub) begin
      res = quiet_nan;
      inv = 1'b1;
    end else if (ux.inf | uy.inf) begin
      res = pack(ps, e_ones, '0, dbl);
    end else if (uz.inf) begin
      res = pack(zs, e_ones, '0, dbl);
    end else if (sum == '0) begin
      // like signs keep their sign; cancellation depends on mode
      res = pack(eff_sub ? (rm == RM_DOWN) : ps,
                 11'h000, '0, dbl);
    end else if (er > bias) begin
      res = ovf_inf ? pack(sb, e_ones, '0, dbl)
                    : pack(sb, e_max, `FRAC_ONES, dbl);
    end else begin
      res = pack(sb, ef, mt[51:0], dbl);
    end
    fma_elem = {inv, res};
  endfunction

  // ========================================================
  // operand routing and lane assembly
  fma_op_type op;
  logic [`VEC_BITS-1:0] x_v;
  logic [`VEC_BITS-1:0] y_v;
  logic [`VEC_BITS-1:0] z_v;
  logic [`VEC_BITS-1:0] lanes_dp;
  logic [`VEC_BITS-1:0] lanes_sp;
  logic [`VEC_BITS-1:0] res_d;
  logic [`DP_BITS:0] r;
  logic inv_d;
  logic valid_q;
  logic [VEC_W-1:0] result_q;
  logic invalid_q;
  logic sticky_q;
  logic sticky_d;

  // issuer supplies mode, precision and width with each request
  assign op = req_i.op;

  always_comb begin
    case (op.order)
      ORD_213: begin
        x_v = req_i.src2;
        y_v = req_i.src1;
        z_v = req_i.src3;
      end
      ORD_231: begin
        x_v = req_i.src2;
        y_v = req_i.src3;
        z_v = req_i.src1;
      end
      default: begin
        x_v = req_i.src1;
        y_v = req_i.src3;
        z_v = req_i.src2;
      end
    endcase
  end

  // every lane is built for both precisions; only one is used
  always_comb begin
    lanes_dp = '0;
    lanes_sp = '0;
    inv_d = 1'b0;
    r = '0;
    for (int i = 0; i < `DP_LANES; i++) begin
      r = fma_elem(x_v[i*`DP_BITS +: `DP_BITS],
                   y_v[i*`DP_BITS +: `DP_BITS],
                   z_v[i*`DP_BITS +: `DP_BITS],
                   1'b1, op.variant, op.rm);
      lanes_dp[i*`DP_BITS +: `DP_BITS] = r[`DP_BITS-1:0];
      if (op.dbl && (i == 0 || (!op.scalar
          && (op.wide || i < `DP_LANES / 2)))) begin
        inv_d = inv_d | r[`DP_BITS];
      end
    end
    for (int j = 0; j < `SP_LANES; j++) begin
      r = fma_elem({32'h0, x_v[j*`SP_BITS +: `SP_BITS]},
                   {32'h0, y_v[j*`SP_BITS +: `SP_BITS]},
                   {32'h0, z_v[j*`SP_BITS +: `SP_BITS]},
                   1'b0, op.variant, op.rm);
      lanes_sp[j*`SP_BITS +: `SP_BITS] = r[`SP_BITS-1:0];
      if (!op.dbl && (j == 0 || (!op.scalar
          && (op.wide || j < `SP_LANES / 2)))) begin
        inv_d = inv_d | r[`DP_BITS];
      end
    end
  end

  always_comb begin
    if (op.scalar) begin
      // destination is source one; element zero is replaced and the upper half cleared
      res_d = {{`HALF_BITS{1'b0}},
               req_i.src1[`HALF_BITS-1:0]};
      if (op.dbl) begin
        res_d[`DP_BITS-1:0] = lanes_dp[`DP_BITS-1:0];
      end else begin
        res_d[`SP_BITS-1:0] = lanes_sp[`SP_BITS-1:0];
      end
    end else begin
      res_d = op.dbl ? lanes_dp : lanes_sp;
      if (!op.wide) begin
        // narrow packed form also clears the upper half
        res_d[`VEC_BITS-1:`HALF_BITS] = '0;
      end
    end
  end

  // ========================================================
  // registers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_q <= '0;
    end else if (valid_i) begin
      result_q <= res_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      invalid_q <= 1'b0;
    end else begin
      invalid_q <= valid_i & inv_d;
    end
  end

  // a new event beats a clear in the same cycle
  assign sticky_d = (sticky_q & ~flag_clear_i) | (valid_i & inv_d);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sticky_q <= 1'b0;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  assign valid_o = valid_q;
  assign result_o = result_q;
  assign invalid_o = invalid_q;
  assign invalid_op_sticky_flag_o = sticky_q;

endmodule

//--- hw/fma_pkg.sv
// types shared by the fused multiply-add datapath
`include "fma_defs.svh"

package fma_pkg;

  // ========================================================
  // operation descriptors
  typedef enum logic [1:0] {
    RM_NEAREST,
    RM_DOWN,
    RM_UP,
    RM_ZERO
  } rm_type;

  typedef enum logic [1:0] {
    ORD_132,
    ORD_213,
    ORD_231
  } order_type;

  typedef struct packed {
    logic neg_prod;
    logic neg_addend;
  } variant_type;

  typedef struct packed {
    logic dbl;
    logic scalar;
    logic wide;
    variant_type variant;
    order_type order;
    rm_type rm;
  } fma_op_type;

  typedef struct packed {
    fma_op_type op;
    logic [`VEC_BITS-1:0] src1;
    logic [`VEC_BITS-1:0] src2;
    logic [`VEC_BITS-1:0] src3;
  } fma_req_type;

  // ========================================================
  // unpacked element
  typedef struct packed {
    logic sgn;
    logic signed [`EXP_W-1:0] expo;
    logic [`SIG_W-1:0] sig;
    logic zero;
    logic inf;
    logic nan;
    logic signaling_nan;
  } operand_type;

endpackage
